/* hw/macsec_ctx_defines.svh */
// Constants for the MACsec context, packet-number and replay block.
// Included by the package and the design; holds definitions only.
`ifndef MACSEC_CTX_DEFINES_SVH
`define MACSEC_CTX_DEFINES_SVH

// Context control word encodings
`define TOP_EGRESS 4'h6
`define TOP_INGRESS 4'hF
`define ALG_AES128 3'h5
`define ALG_AES256 3'h7
`define DIGEST_SINGLE 2'h2
`define AUTH_GHASH 3'h4
`define SEQT_32 2'h1
`define CW_RSVD_MASK 32'h00101F10

// Transform record layout, in 32-bit words
`define REC_WORDS 20
`define KEY_WORDS_128 4'h4
`define KEY_WORDS_256 4'h8
`define SEQ_IDX_128 5'h0A
`define MASK_IDX_128 5'h0B
`define SEQ_IDX_256 5'h0E
`define MASK_IDX_256 5'h0F
`define SEQ_MAX 32'hFFFFFFFF

// Register map, byte addresses
`define REG_IRQ 12'h000
`define REG_THRESH 12'h004
`define REG_LAST 12'h008
`define REC_REGION 2'h1
`define IRQ_STAT_LSB 4
`define IRQ_EN_LSB 20
`define THRESH_RST 32'hFFFFFFFF

`endif

/* hw/macsec_ctx_pkg.sv */
// Types for the MACsec context, packet-number and replay block.
// Assumes the defines header is on the include path.
`include "macsec_ctx_defines.svh"

package macsec_ctx_pkg;

   typedef enum logic [1:0] {
      DIR_EGRESS,
      DIR_INGRESS,
      DIR_INVALID
   } dir_e;

   typedef struct packed {
      logic ctx_id_present;
      logic mask_present;
      logic [1:0] seq_type;
      logic [1:0] an;
      logic [2:0] auth_alg;
      logic [1:0] digest_type;
      logic rsvd20;
      logic [2:0] cipher;
      logic key_load;
      logic icv_encrypt;
      logic iv_uses_pn_flag;
      logic seq_update;
      logic [4:0] rsvd12_8;
      logic iv_third_word_present;
      logic iv_second_word_present;
      logic iv_first_word_present;
      logic rsvd4;
      logic [3:0] pkt_type;
   } ctrl_word_s;

   typedef struct packed {
      logic valid;
      logic invalid;
      logic cfg_warn;
      logic seq_err;
      logic replay_error_flag;
      logic egress;
      logic [1:0] an;
      logic key256;
      logic [3:0] key_words;
      logic iv_uses_pn_flag;
      logic icv_encrypt;
      logic key_load;
      logic [31:0] pn;
   } result_s;

   typedef struct packed {
      logic wreq;
      logic [31:0] rdata;
      logic [1:0] irq_status;
      logic [1:0] irq_en;
      logic [31:0] pn_threshold_value;
      result_s res;
      logic irq;
   } state_s;

endpackage

/* hw/macsec_context_seq_replay.sv */
// Per-SA transform record store, context word decode, egress packet
// number counter with rollover, ingress replay window check, and the
// crypto interrupt status. Assumes the engine presents one request per
// frame on clk_sys and software fills a record before enabling its flow.
`include "macsec_ctx_defines.svh"

// Operation
// - Type field 0110b egress, 1111b ingress; anything else is invalid.
// - Sequence-update flag enables writing the sequence number back.
// - Iv_uses_pn_flag flag means the IV is built from the packet number.
// - ICV-encrypt flag makes the engine encrypt the ICV.
// - Key-load flag loads the cipher key from the record.
// - Cipher 101b is AES-CTR-128, 111b is AES-CTR-256.
// - Egress inserts the association number; ingress keeps it 00b.
// - Sequence type 01b means 32-bit PN; ingress mask is the window.
// - Mask-present flag is 0 for egress, 1 for ingress.
// - Reserved bits written zero, read values ignored.
// - Key words are little-endian; count follows the AES key length.
// - Egress stored value is PN minus one, incremented per packet.
// - Egress rollover flags a sequence error and leaves context unchanged.
// - Ingress starts at one; mask zero enforces strict ordering.
// - Ingress PN at or above next updates next to PN plus one.
// - Below next but in window accepts; below window sets replay error.
// - Status bit 4 sets when an egress PN exceeds the threshold.
// - Status bit 5 sets when an egress frame finds the stored PN at its maximum (rollover).
// - Only the sequence word of a record is ever written by hardware.
module macsec_context_seq_replay #(
   parameter int NUM_SA = 8,
   parameter int SA_W = 3
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic req_valid,
   input wire logic [SA_W-1:0] req_sa,
   input wire logic [31:0] req_pn,
   output macsec_ctx_pkg::result_s res,
   output logic crypto_irq
);

   // Record words are data, not control, so they carry no reset
   logic [31:0] mem [NUM_SA][`REC_WORDS];

   macsec_ctx_pkg::state_s st_q;
   macsec_ctx_pkg::state_s st_d;
   macsec_ctx_pkg::ctrl_word_s cw;
   macsec_ctx_pkg::dir_e dir;

   logic bus_req;
   logic bus_fire;
   logic rec_hit;
   logic [SA_W-1:0] bus_sa;
   logic [4:0] bus_word;
   logic [31:0] wmask;
   logic [31:0] rd_val;
   logic sa_ok;
   logic key256;
   logic cfg_ok;
   logic cfg_warn;
   logic [4:0] seq_idx;
   logic [4:0] mask_idx;
   logic [31:0] seq_val;
   logic [31:0] mask_val;
   logic [31:0] seq_inc;
   logic [31:0] pn_inc;
   logic [32:0] win_sum;
   logic eng_we;
   logic [31:0] eng_wdata;
   logic rec_wr;
   logic irq_wr;
   logic thresh_wr;
   logic egr_roll;
   logic egr_over;
   logic igr_fresh;
   logic igr_stale;

   // Bus decode: records live at 0x400 + sa*0x80 + word*4
   assign bus_req = avs_read | avs_write;
   assign bus_fire = bus_req & ~st_q.wreq;
   assign bus_sa = SA_W'(avs_address[9:7]);
   assign bus_word = avs_address[6:2];
   assign rec_hit = (avs_address[11:10] == `REC_REGION)
                    && (32'(avs_address[9:7]) < NUM_SA)
                    && (32'(bus_word) < `REC_WORDS);

   // Writes act only at the edge that completes the access
   assign rec_wr = bus_fire & avs_write & rec_hit;
   assign irq_wr = bus_fire & avs_write & ~rec_hit & (avs_address == `REG_IRQ);
   assign thresh_wr = bus_fire & avs_write & ~rec_hit & (avs_address == `REG_THRESH);

   for (genvar b = 0; b < 4; b++) begin : g_be
      assign wmask[8*b +: 8] = {8{avs_byteenable[b]}};
   end

   // Context decode for the requested SA
   assign sa_ok = 32'(req_sa) < NUM_SA;
   assign cw = macsec_ctx_pkg::ctrl_word_s'(mem[req_sa][0]);
   assign key256 = cw.cipher == `ALG_AES256;
   assign seq_idx = key256 ? `SEQ_IDX_256 : `SEQ_IDX_128;
   assign mask_idx = key256 ? `MASK_IDX_256 : `MASK_IDX_128;
   assign seq_val = mem[req_sa][seq_idx];
   assign mask_val = mem[req_sa][mask_idx];
   assign seq_inc = seq_val + 32'h1;
   assign pn_inc = req_pn + 32'h1;
   assign win_sum = {1'b0, req_pn} + {1'b0, mask_val};

   // Rollover is caught before the add, so the stored egress word never wraps
   assign egr_roll = seq_val == `SEQ_MAX;
   assign egr_over = seq_inc > st_q.pn_threshold_value;
   assign igr_fresh = req_pn >= seq_val;
   // The 33-bit sum keeps PN plus a large window from wrapping past the top
   assign igr_stale = win_sum < {1'b0, seq_val};

   // Unsupported cipher or sequence type cannot be processed at all
   assign cfg_ok = ((cw.cipher == `ALG_AES128) || key256)
                   && (cw.seq_type == `SEQT_32);

   // Settings software owns; reported, not enforced, so a slightly
   // wrong record still passes traffic while software is told about it
   always_comb begin
      cfg_warn = 1'b0;
      if (!cw.iv_first_word_present || !cw.iv_second_word_present) begin
         cfg_warn = 1'b1;
      end
      if (cw.iv_third_word_present) begin
         cfg_warn = 1'b1;
      end
      if (!cw.seq_update) begin
         cfg_warn = 1'b1;
      end
      if (!cw.iv_uses_pn_flag) begin
         cfg_warn = 1'b1;
      end
      if (!cw.icv_encrypt) begin
         cfg_warn = 1'b1;
      end
      if (!cw.key_load) begin
         cfg_warn = 1'b1;
      end
      if (cw.digest_type != `DIGEST_SINGLE) begin
         cfg_warn = 1'b1;
      end
      if (cw.auth_alg != `AUTH_GHASH) begin
         cfg_warn = 1'b1;
      end
      if (!cw.ctx_id_present) begin
         cfg_warn = 1'b1;
      end
      if (dir == macsec_ctx_pkg::DIR_INGRESS && cw.an != 2'h0) begin
         cfg_warn = 1'b1;
      end
   end

   always_comb begin
      dir = macsec_ctx_pkg::DIR_INVALID;
      if (sa_ok && cfg_ok) begin
         // Reserved bits are not looked at
         if (cw.pkt_type == `TOP_EGRESS && !cw.mask_present) begin
            dir = macsec_ctx_pkg::DIR_EGRESS;
         end else if (cw.pkt_type == `TOP_INGRESS && cw.mask_present) begin
            dir = macsec_ctx_pkg::DIR_INGRESS;
         end
      end
   end

   // Register read mux
   always_comb begin
      rd_val = 32'h0;
      if (rec_hit) begin
         rd_val = mem[bus_sa][bus_word];
      end else begin
         unique case (avs_address)
            `REG_IRQ: begin
               rd_val[`IRQ_STAT_LSB +: 2] = st_q.irq_status;
               rd_val[`IRQ_EN_LSB +: 2] = st_q.irq_en;
            end
            `REG_THRESH: begin
               rd_val = st_q.pn_threshold_value;
            end
            `REG_LAST: begin
               rd_val[1] = st_q.res.invalid;
               rd_val[2] = st_q.res.cfg_warn;
               rd_val[3] = st_q.res.seq_err;
               rd_val[4] = st_q.res.replay_error_flag;
               rd_val[5] = st_q.res.egress;
               rd_val[7:6] = st_q.res.an;
               // Only the low half of the number fits beside the flags
               rd_val[31:16] = st_q.res.pn[15:0];
            end
            default: begin
               rd_val = 32'h0;
            end
         endcase
      end
   end

   always_comb begin
      st_d = st_q;
      eng_we = 1'b0;
      eng_wdata = seq_inc;
      st_d.res.valid = 1'b0;

      // One wait cycle per access; data is set up while waiting
      st_d.wreq = ~(bus_req & st_q.wreq);
      if (bus_req && st_q.wreq) begin
         st_d.rdata = rd_val;
      end

      // Clear is applied first so that an event in the same cycle wins
      if (irq_wr) begin
         // Write one to clear; enables are plain bits
         if (avs_byteenable[0]) begin
            st_d.irq_status = st_q.irq_status
                              & ~avs_writedata[`IRQ_STAT_LSB +: 2];
         end
         if (avs_byteenable[2]) begin
            st_d.irq_en = avs_writedata[`IRQ_EN_LSB +: 2];
         end
      end
      if (thresh_wr) begin
         st_d.pn_threshold_value = (st_q.pn_threshold_value & ~wmask)
                                   | (avs_writedata & wmask);
      end

      if (req_valid) begin
         st_d.res.valid = 1'b1;
         st_d.res.invalid = 1'b0;
         st_d.res.cfg_warn = cfg_warn;
         st_d.res.seq_err = 1'b0;
         st_d.res.replay_error_flag = 1'b0;
         st_d.res.egress = 1'b0;
         st_d.res.an = 2'h0;
         st_d.res.key256 = key256;
         st_d.res.key_words = key256 ? `KEY_WORDS_256 : `KEY_WORDS_128;
         st_d.res.iv_uses_pn_flag = cw.iv_uses_pn_flag;
         st_d.res.icv_encrypt = cw.icv_encrypt;
         st_d.res.key_load = cw.key_load;
         st_d.res.pn = req_pn;
         unique case (dir)
            macsec_ctx_pkg::DIR_EGRESS: begin
               st_d.res.egress = 1'b1;
               st_d.res.an = cw.an;
               if (egr_roll) begin
                  // Context left alone, so every later frame errors too
                  st_d.res.seq_err = 1'b1;
                  st_d.irq_status[1] = 1'b1;
               end else begin
                  st_d.res.pn = seq_inc;
                  eng_we = cw.seq_update;
                  eng_wdata = seq_inc;
                  if (egr_over) begin
                     st_d.irq_status[0] = 1'b1;
                  end
               end
            end
            macsec_ctx_pkg::DIR_INGRESS: begin
               if (igr_fresh) begin
                  eng_we = cw.seq_update;
                  eng_wdata = pn_inc;
               end else if (igr_stale) begin
                  // Mask of zero makes any older PN fail
                  st_d.res.replay_error_flag = 1'b1;
               end
            end
            macsec_ctx_pkg::DIR_INVALID: begin
               st_d.res.invalid = 1'b1;
            end
         endcase
      end

      st_d.irq = |(st_d.irq_status & st_d.irq_en);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.wreq <= 1'b1;
         st_q.pn_threshold_value <= `THRESH_RST;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // Engine write follows the bus write so it wins on the same word
   always_ff @(posedge clk_sys) begin
      if (ce) begin
         if (rec_wr) begin
            mem[bus_sa][bus_word] <= (mem[bus_sa][bus_word] & ~wmask)
                                     | (avs_writedata & wmask);
         end
         if (req_valid && eng_we) begin
            mem[req_sa][seq_idx] <= eng_wdata;
         end
      end
   end

   assign avs_readdata = st_q.rdata;
   assign avs_waitrequest = st_q.wreq;
   assign res = st_q.res;
   assign crypto_irq = st_q.irq;

endmodule

/* testbench/macsec_ctx_chk.sv */
// Port checker for the context, packet-number and replay block.
// Bound to the top module below; sees only that module's ports.
module macsec_ctx_chk #(
   parameter int NUM_SA = 8,
   parameter int SA_W = 3
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic req_valid,
   input wire logic [SA_W-1:0] req_sa,
   input wire macsec_ctx_pkg::result_s res,
   input wire logic crypto_irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   a_res_follows: assert property (req_valid && ce |=> res.valid)
      else $error("no result after request");
   a_res_quiet: assert property (ce && !req_valid |=> !res.valid)
      else $error("result without request");
   a_roll_egress: assert property (res.valid && res.seq_err |-> res.egress)
      else $error("sequence error outside egress");
   a_replay_ingress: assert property (res.valid && res.replay_error_flag |-> !res.egress)
      else $error("replay error outside ingress");
   a_key_count: assert property (res.valid && !res.invalid |->
      res.key_words == (res.key256 ? 4'h8 : 4'h4)) else $error("key word count wrong");
   a_irq_level: assert property (avs_read && !avs_waitrequest && avs_address == 12'h000 &&
      !$past(req_valid) && !$past(req_valid, 2) && !$past(req_valid, 3) |->
      crypto_irq == |(avs_readdata[5:4] & avs_readdata[21:20])) else $error("irq level wrong");
   a_wait_once: assert property (ce && (avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest ##1 avs_waitrequest) else $error("bus wait not one cycle");
   a_pn_step: assert property (req_valid ##1 req_valid && req_sa == $past(req_sa) ##1
      res.egress && !res.invalid && !res.seq_err && !res.cfg_warn && $past(res.egress) |->
      res.pn == $past(res.pn) + 32'h1) else $error("egress number did not step");
   c_roll: cover property (res.valid && res.seq_err);
   c_replay: cover property (res.valid && res.replay_error_flag);
   c_irq: cover property (crypto_irq);
endmodule

bind macsec_context_seq_replay macsec_ctx_chk #(.NUM_SA(NUM_SA), .SA_W(SA_W)) i_chk (
   .clk_sys, .rst_n, .ce, .avs_address, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .req_valid, .req_sa, .res, .crypto_irq);

/* testbench/tb_macsec_ctx.sv */
// Self-checking bench for the context, packet-number and replay block.
// Assumes the package is compiled first and the defines header is on the path.
`include "macsec_ctx_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst_n, ce, avs_read, avs_write, avs_waitrequest, req_valid, crypto_irq;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, req_pn, v, w;
   logic [3:0] avs_byteenable;
   logic [2:0] req_sa;
   logic [1:0] an;
   macsec_ctx_pkg::result_s res;
   logic [31:0] bq[$];
   logic [37:0] rq[$];
   int errors, tests_run, seed, i;
   // Six SAs on a 3-bit index so that an out-of-range SA can be requested
   macsec_context_seq_replay #(.NUM_SA(6), .SA_W(3)) i_dut (.clk_sys, .rst_n, .ce,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .req_valid, .req_sa, .req_pn, .res, .crypto_irq);
   task automatic summarize();
      $display("tests_run=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmp_bus(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("unexpected read at %0t: %h vs %h", $time, g, e);
      end
   endtask
   task automatic cmp_res(input logic [37:0] g, input logic [37:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("unexpected result at %0t: %h vs %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      if (n >= 40) begin
         errors++;
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      bq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic fr(input logic [2:0] s, input logic [31:0] p, input logic [37:0] e);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_sa <= s;
      req_pn <= p;
      rq.push_back(e);
   endtask
   function automatic logic [11:0] ra(input int s, input int wd);
      return 12'h400 + 12'(s * 128 + wd * 4);
   endfunction
   // Legal MACsec control word; ingress flips type and mask flag
   function automatic logic [31:0] cw(input bit ing, input bit k, input logic [1:0] a);
      return 32'h924BE066 | (k ? 32'h40000 : 32'h0) | (ing ? 32'h40000009 : 32'h0) | {4'h0, a, 26'h0};
   endfunction
   always @(posedge clk_sys) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         cmp_bus(avs_readdata, bq.pop_front());
      end
      if (res.valid === 1'b1) begin
         cmp_res(res.invalid ? {1'b1, 37'h0} : {1'b0, res.seq_err, res.replay_error_flag,
            res.egress, res.an, res.egress && !res.seq_err ? res.pn : 32'h0}, rq.pop_front());
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      summarize();
   end
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      avs_address = 12'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      req_valid = 1'b0;
      req_sa = 3'h0;
      req_pn = 32'h0;
      errors = 0;
      tests_run = 0;
      seed = 55;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(`REG_THRESH, `THRESH_RST);
      rd(`REG_IRQ, 32'h0);
      bus(1'b1, 12'h00C, 32'h5A5A5A5A);
      rd(12'h00C, 32'h0);
      $display("test 1 done");
      an = 2'($random(seed));
      v = cw(1'b0, 1'b0, an);
      bus(1'b1, ra(0, 0), v);
      bus(1'b1, ra(0, `SEQ_IDX_128), 32'h0);
      for (i = 1; i <= 3; i++) begin
         fr(3'h0, 32'($random(seed)), {4'b0001, an, 32'(i)});
      end
      rd(ra(0, `SEQ_IDX_128), 32'h3);
      rd(ra(0, 0), v);
      rd(`REG_LAST, {16'h3, 8'h0, an, 6'b100000});
      $display("test 2 done");
      an = 2'($random(seed));
      bus(1'b1, ra(1, 0), cw(1'b0, 1'b1, an));
      bus(1'b1, ra(1, `SEQ_IDX_256), 32'h4);
      bus(1'b1, `REG_IRQ, 32'h00300000);
      bus(1'b1, `REG_THRESH, 32'h5);
      fr(3'h1, 32'h0, {4'b0001, an, 32'h5});
      rd(`REG_IRQ, 32'h00300000);
      fr(3'h1, 32'h0, {4'b0001, an, 32'h6});
      rd(`REG_IRQ, 32'h00300010);
      rd(`REG_IRQ, 32'h00300010);
      // Clear threshold status and leave only its enable on
      bus(1'b1, `REG_IRQ, 32'h00100010);
      rd(`REG_IRQ, 32'h00100000);
      bus(1'b1, ra(1, `SEQ_IDX_256), `SEQ_MAX);
      fr(3'h1, 32'h0, {4'b0101, an, 32'h0});
      fr(3'h1, 32'h0, {4'b0101, an, 32'h0});
      rd(ra(1, `SEQ_IDX_256), `SEQ_MAX);
      rd(`REG_IRQ, 32'h00100020);
      bus(1'b1, `REG_IRQ, 32'h00000020);
      rd(`REG_IRQ, 32'h0);
      $display("test 3 done");
      bus(1'b1, ra(2, 0), cw(1'b1, 1'b0, 2'h0));
      bus(1'b1, ra(2, `SEQ_IDX_128), 32'h1);
      bus(1'b1, ra(2, `MASK_IDX_128), 32'h0);
      fr(3'h2, 32'h5, 38'h0);
      fr(3'h2, 32'h5, {4'b0010, 34'h0});
      fr(3'h2, 32'h6, 38'h0);
      bus(1'b1, ra(2, `MASK_IDX_128), 32'h3);
      fr(3'h2, 32'h4, 38'h0);
      fr(3'h2, 32'h3, {4'b0010, 34'h0});
      rd(ra(2, `SEQ_IDX_128), 32'h7);
      v = 32'h7 + (32'($random(seed)) & 32'hFFFF);
      fr(3'h2, v, 38'h0);
      rd(ra(2, `SEQ_IDX_128), v + 32'h1);
      $display("test 4 done");
      bus(1'b1, ra(3, `SEQ_IDX_128), 32'h0);
      v = 32'h0;
      // Every type code, cipher codes 0 to 6, then a wrong sequence type
      for (i = 0; i < 24; i++) begin
         w = cw(1'b0, 1'b0, 2'h0);
         w = i < 16 ? (w & ~32'hF) | 32'(i) : i < 23 ? (w & ~32'hE0000) | 32'(i - 16) << 17 : w & ~32'h30000000;
         bus(1'b1, ra(3, 0), w);
         if (i == 6 || i == 21) begin
            v++;
            fr(3'h3, 32'h0, {6'b000100, v});
         end else begin
            fr(3'h3, 32'h0, {1'b1, 37'h0});
         end
      end
      bus(1'b1, ra(7, 0), cw(1'b0, 1'b0, 2'h0));
      fr(3'h7, 32'h0, {1'b1, 37'h0});
      // Update flag off: frame still runs, warns, and leaves the record alone
      bus(1'b1, ra(3, 0), cw(1'b0, 1'b0, 2'h0) & ~32'h2000);
      fr(3'h3, 32'h0, {6'b000100, 32'h3});
      rd(`REG_LAST, {16'h3, 8'h0, 8'h24});
      rd(ra(3, `SEQ_IDX_128), 32'h2);
      bus(1'b1, 12'h00C, 32'h0);
      $display("test 5 done");
      summarize();
   end
endmodule
